// [shared/sar_adc_pkg.sv]
// Purpose: constants and types for the sar converter control block
// Assumes: apb register access, one 100 MHz clock
// Notes: offsets are byte addresses of aligned 32-bit words
package sar_adc_pkg;
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_RESULT         = 8'h04;
    localparam logic [7:0] ADDR_CLOCK_SELECT   = 8'h08;

    localparam int         FLAG_BIT      = 7;
    localparam int         IEN_BIT       = 6;
    localparam int         CONT_BIT      = 5;
    localparam int         CH_LSB        = 0;
    localparam int         CH_W          = 5;
    localparam int         DIV_LSB       = 5;
    localparam int         SRC_BIT       = 4;
    localparam int         RES_W         = 8;

    localparam logic [4:0] CH_POWER_OFF  = 5'h1f;
    localparam logic [4:0] CH_RESET      = 5'h1f;
    localparam logic [2:0] DIV_RESET     = 3'h0;
    localparam logic       SRC_RESET     = 1'h0;

    localparam int         CONV_CYCLES   = 16;
    localparam logic [3:0] CNT_FIRST     = 4'h1;
    localparam logic [3:0] CNT_RESOLVE   = 4'h8;
    localparam logic [3:0] CNT_LAST      = 4'(CONV_CYCLES - 1);
    localparam logic [7:0] SAR_START     = 8'h80;
    localparam logic [3:0] DIV16_LAST    = 4'hf;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b11
    } conv_state_t;
endpackage

// [verilog/conv_clock_gen.sv]
// Purpose: internal converter clock as a one-cycle tick in the bus domain
// Assumes: crystal_clock is sampled as a synchronous input
// Notes: tick marks each rising edge of the divided converter clock
module conv_clock_gen #(
    parameter int DIV_W = 4
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       crystal_clock,
    input  wire logic       src_bus,
    input  wire logic [2:0] prescale,
    input  wire logic       run,
    output logic            tick
);
    if (DIV_W < 4) begin : g_chk
        $error("conv_clock_gen: DIV_W must be at least 4");
    end

    typedef struct packed {
        logic             xprev;
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } gen_state_t;

    gen_state_t s_ff;
    gen_state_t nxt_s;
    logic             src_edge;
    logic [DIV_W-1:0] div_last;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.xprev = crystal_clock;
        src_edge = src_bus | (crystal_clock & ~s_ff.xprev);
        if (prescale[2]) begin
            div_last = DIV_W'(sar_adc_pkg::DIV16_LAST);
        end else begin
            div_last = DIV_W'((4'h1 << prescale[1:0]) - 4'h1);
        end
        nxt_s.tick = 1'b0;
        if (!run) begin
            nxt_s.cnt = '0;
        end else if (src_edge) begin
            if (s_ff.cnt >= div_last) begin
                nxt_s.cnt = '0;
                nxt_s.tick = 1'b1;
            end else begin
                nxt_s.cnt = s_ff.cnt + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tick = s_ff.tick;
endmodule

// [verilog/sar_adc_control_regs.sv]
// Purpose: register file, sequencer and sar logic of the 8-bit converter
// Assumes: apb slave, one wait state; comparator input synchronous to pclk
// Notes: converter clock runs only as an enable tick inside pclk domain
//
// Design decisions made here: the APB interface to the registers and the register offsets.
module sar_adc_control_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              crystal_clock,
    input  wire logic              stop_mode,
    input  wire logic              cmp_in,
    output logic      [4:0]        selected_analog_input,
    output logic                   conv_power_on,
    output logic      [7:0]        dac_code,
    output logic                   sample_hold,
    output logic                   conv_irq
);
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk
        $error("sar_adc_control_regs: ADDR_W must be 4 to 32");
    end

    typedef struct packed {
        sar_adc_pkg::conv_state_t state;
        logic [3:0]               cnt;
        logic [7:0]               sar;
        logic [7:0]               result;
        logic                     done;
        logic                     ien;
        logic                     cont;
        logic [4:0]               ch;
        logic                     src;
        logic [2:0]               div;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
        logic                     irq;
        logic                     power_on;
        logic                     sample;
    } adc_state_t;

    adc_state_t s_ff;
    adc_state_t nxt_s;
    logic       tick;
    logic       acc;
    logic       fin;
    logic       wr_sc;
    logic       wr_clk;
    logic       rd_res;
    logic       done_evt;
    logic       powered;
    logic [2:0] bit_idx;
    logic [7:0] a_addr;

    assign a_addr = 8'(paddr);

    conv_clock_gen #(
        .DIV_W(4)
    ) u_clk (
        .pclk          (pclk),
        .presetn       (presetn),
        .crystal_clock (crystal_clock),
        .src_bus       (s_ff.src),
        .prescale      (s_ff.div),
        .run           (s_ff.ch != sar_adc_pkg::CH_POWER_OFF && !stop_mode),
        .tick          (tick)
    );

    always_comb begin
        nxt_s    = s_ff;
        acc      = psel && penable;
        fin      = acc && s_ff.pready;
        wr_sc    = fin && pwrite && a_addr == sar_adc_pkg::ADDR_STATUS_CONTROL;
        wr_clk   = fin && pwrite && a_addr == sar_adc_pkg::ADDR_CLOCK_SELECT;
        rd_res   = fin && !pwrite && a_addr == sar_adc_pkg::ADDR_RESULT;
        done_evt = 1'b0;
        bit_idx  = 3'(sar_adc_pkg::CNT_LAST - s_ff.cnt);
        // apb answer one cycle into the access phase
        nxt_s.pready = acc && !s_ff.pready;
        if (acc && !s_ff.pready) begin
            nxt_s.pslverr = 1'b0;
            nxt_s.prdata  = 32'h0000_0000;
            case (a_addr)
                sar_adc_pkg::ADDR_STATUS_CONTROL: begin
                    nxt_s.prdata[sar_adc_pkg::FLAG_BIT] = s_ff.done && !s_ff.ien;
                    nxt_s.prdata[sar_adc_pkg::IEN_BIT]  = s_ff.ien;
                    nxt_s.prdata[sar_adc_pkg::CONT_BIT] = s_ff.cont;
                    nxt_s.prdata[sar_adc_pkg::CH_LSB +: sar_adc_pkg::CH_W] = s_ff.ch;
                end
                sar_adc_pkg::ADDR_RESULT: begin
                    nxt_s.prdata[sar_adc_pkg::RES_W-1:0] = s_ff.result;
                end
                sar_adc_pkg::ADDR_CLOCK_SELECT: begin
                    nxt_s.prdata[sar_adc_pkg::DIV_LSB +: 3] = s_ff.div;
                    nxt_s.prdata[sar_adc_pkg::SRC_BIT]      = s_ff.src;
                end
                default: begin
                    nxt_s.pslverr = 1'b1;
                end
            endcase
        end else if (fin) begin
            nxt_s.pslverr = 1'b0;
        end
        if (wr_sc) begin
            nxt_s.ien  = pwdata[sar_adc_pkg::IEN_BIT];
            nxt_s.cont = pwdata[sar_adc_pkg::CONT_BIT];
            nxt_s.ch   = pwdata[sar_adc_pkg::CH_LSB +: sar_adc_pkg::CH_W];
        end
        if (wr_clk) begin
            nxt_s.div = pwdata[sar_adc_pkg::DIV_LSB +: 3];
            nxt_s.src = pwdata[sar_adc_pkg::SRC_BIT];
        end
        powered = nxt_s.ch != sar_adc_pkg::CH_POWER_OFF;
        // conversion sequencer, WAIT and RUN step once per converter clock tick, IDLE leaves without one
        case (s_ff.state)
            sar_adc_pkg::ST_IDLE: begin
                if (s_ff.cont) begin
                    nxt_s.state = sar_adc_pkg::ST_WAIT;
                end
            end
            sar_adc_pkg::ST_WAIT: begin
                if (tick) begin
                    nxt_s.state = sar_adc_pkg::ST_RUN;
                    nxt_s.cnt   = sar_adc_pkg::CNT_FIRST;
                    nxt_s.sar   = sar_adc_pkg::SAR_START;
                end
            end
            sar_adc_pkg::ST_RUN: begin
                if (tick) begin
                    if (s_ff.cnt >= sar_adc_pkg::CNT_RESOLVE) begin
                        if (!cmp_in) begin
                            nxt_s.sar[bit_idx] = 1'b0;
                        end
                        if (bit_idx != 3'h0) begin
                            nxt_s.sar[bit_idx - 3'h1] = 1'b1;
                        end
                    end
                    if (s_ff.cnt == sar_adc_pkg::CNT_LAST) begin
                        done_evt     = 1'b1;
                        nxt_s.result = nxt_s.sar;
                        if (s_ff.cont) begin
                            nxt_s.state = sar_adc_pkg::ST_WAIT;
                        end else begin
                            nxt_s.state = sar_adc_pkg::ST_IDLE;
                        end
                    end else begin
                        nxt_s.cnt = s_ff.cnt + 4'h1;
                    end
                end
            end
            default: begin
                nxt_s.state = sar_adc_pkg::ST_IDLE;
            end
        endcase
        if (wr_sc) begin
            nxt_s.state = sar_adc_pkg::ST_WAIT;
        end
        if (!powered || stop_mode) begin
            nxt_s.state = sar_adc_pkg::ST_IDLE;
        end
        // flag: a completion in the clearing cycle wins
        if (wr_sc || rd_res) begin
            nxt_s.done = 1'b0;
        end
        if (done_evt) begin
            nxt_s.done = 1'b1;
        end
        nxt_s.irq      = nxt_s.done && nxt_s.ien;
        nxt_s.power_on = powered;
        nxt_s.sample   = nxt_s.state == sar_adc_pkg::ST_RUN
                         && nxt_s.cnt < sar_adc_pkg::CNT_RESOLVE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff          <= '0;
            s_ff.state    <= sar_adc_pkg::ST_IDLE;
            s_ff.ch       <= sar_adc_pkg::CH_RESET;
            s_ff.src      <= sar_adc_pkg::SRC_RESET;
            s_ff.div      <= sar_adc_pkg::DIV_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata                = s_ff.prdata;
    assign pready                = s_ff.pready;
    assign pslverr               = s_ff.pslverr;
    assign selected_analog_input = s_ff.ch;
    assign conv_power_on         = s_ff.power_on;
    assign dac_code              = s_ff.sar;
    assign sample_hold           = s_ff.sample;
    assign conv_irq              = s_ff.irq;

    a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
        done_evt |=> s_ff.done)
        else $error("done flag not set after conversion end");

    a_flag_clears: assert property (@(posedge pclk) disable iff (!presetn)
        ((wr_sc || rd_res) && !done_evt) |=> !s_ff.done)
        else $error("done flag not cleared by access");

    a_flag_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && !s_ff.pready && !pwrite && s_ff.ien
         && a_addr == sar_adc_pkg::ADDR_STATUS_CONTROL)
        |=> !prdata[sar_adc_pkg::FLAG_BIT])
        else $error("done flag visible while interrupt enabled");

    a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
        (done_evt && s_ff.ien && !wr_sc) |=> conv_irq)
        else $error("interrupt missing after conversion end");

    a_irq_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_res && !done_evt) |=> !conv_irq)
        else $error("interrupt not dropped on result read");

    a_cont_repeat: assert property (@(posedge pclk) disable iff (!presetn)
        (done_evt && s_ff.cont && !stop_mode && !wr_sc)
        |=> s_ff.state == sar_adc_pkg::ST_WAIT)
        else $error("continuous mode did not rearm");

    a_single_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (done_evt && !s_ff.cont && !wr_sc) |=> s_ff.state == sar_adc_pkg::ST_IDLE)
        else $error("single conversion did not stop");

    a_result_load: assert property (@(posedge pclk) disable iff (!presetn)
        done_evt |=> s_ff.result == $past(nxt_s.sar))
        else $error("result not loaded at conversion end");

    a_power_off: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.ch == sar_adc_pkg::CH_POWER_OFF && !wr_sc) |=> !conv_power_on
        ##0 s_ff.state == sar_adc_pkg::ST_IDLE)
        else $error("converter active with power-off code");

    a_stop_abort: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode |=> s_ff.state == sar_adc_pkg::ST_IDLE)
        else $error("conversion not aborted in stop mode");

    a_start_edge: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.state == sar_adc_pkg::ST_WAIT && tick && !stop_mode && !wr_sc
         && s_ff.ch != sar_adc_pkg::CH_POWER_OFF)
        |=> s_ff.state == sar_adc_pkg::ST_RUN && s_ff.cnt == sar_adc_pkg::CNT_FIRST)
        else $error("conversion did not start on converter clock edge");
endmodule

// [tb/analog_front_model.sv]
// Purpose: analog input mux and comparator facing the converter
// Assumes: comparator output follows dac_code within the same pclk cycle
// Notes: unused codes and power off give a comparator that changes every cycle
module analog_front_model (
    input  wire logic       pclk,
    input  wire logic [4:0] selected_analog_input,
    input  wire logic       conv_power_on,
    input  wire logic [7:0] dac_code,
    output logic            cmp_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       noise;
    logic       valid_ch;
    logic [7:0] level;
    initial noise = 1'b0;
    always @(posedge pclk) noise <= ~noise;
    always_comb begin
        if (selected_analog_input < 5'h0f) begin
            level = 8'(selected_analog_input * 17 + 3);
        end else if (selected_analog_input inside {5'h1c, 5'h1d}) begin
            level = 8'hff;
        end else begin
            level = 8'h00;
        end
    end
    // unused and reserved codes, and power off, leave the comparator unsettled
    assign valid_ch = (selected_analog_input < 5'h0f) || (selected_analog_input > 5'h1b);
    assign cmp_in   = (conv_power_on && valid_ch) ? (level >= dac_code) : noise;
endmodule

// [tb/tb_sar_adc_control_regs.sv]
// Purpose: self-checking bench of the converter control block
// Assumes: one apb wait state, converter tick derived inside pclk domain
// Notes: conversion times are checked as ranges, since the tick phase is free
module tb_sar_adc_control_regs;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_SC  = sar_adc_pkg::ADDR_STATUS_CONTROL;
    localparam logic [7:0] A_RES = sar_adc_pkg::ADDR_RESULT;
    localparam logic [7:0] A_CLK = sar_adc_pkg::ADDR_CLOCK_SELECT;
    typedef struct {logic [4:0] ch; logic [7:0] res;} row_t;
    row_t        rows [7] = '{'{5'h00, 8'h03}, '{5'h07, 8'h7a}, '{5'h08, 8'h8b},
                              '{5'h0e, 8'hf1}, '{5'h1c, 8'hff}, '{5'h1d, 8'hff},
                              '{5'h1e, 8'h00}};
    logic [2:0]  divs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        crystal_clock, stop_mode, cmp_in, conv_power_on, sample_hold, conv_irq;
    logic [7:0]  paddr, dac_code;
    logic [31:0] pwdata, prdata, q;
    logic [4:0]  selected_analog_input;
    logic        err;
    int          fail_count, num_checks, cycles, n, nd;
    sar_adc_control_regs u_sar_adc_control_regs (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .crystal_clock(crystal_clock),
        .stop_mode(stop_mode), .cmp_in(cmp_in), .selected_analog_input(selected_analog_input),
        .conv_power_on(conv_power_on), .dac_code(dac_code), .sample_hold(sample_hold),
        .conv_irq(conv_irq));
    analog_front_model u_analog_front_model (.pclk(pclk),
        .selected_analog_input(selected_analog_input), .conv_power_on(conv_power_on),
        .dac_code(dac_code), .cmp_in(cmp_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            fail_count++;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll_done();
        int k;
        k = 0;
        do begin
            apb(1'b0, A_SC, 32'h0);
            k++;
        end while (q[7] !== 1'b1 && k < 200);
    endtask
    task automatic wait_irq();
        n = 0;
        while (conv_irq !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        crystal_clock <= cycles[1];
        if (cycles == 40000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, stop_mode} = '0;
        paddr = '0;
        pwdata = '0;
        {fail_count, num_checks} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_SC, 32'h0);
        check(q, 32'h1f, "status reset");
        check({31'h0, conv_power_on}, 32'h0, "powered off at reset");
        apb(1'b0, A_CLK, 32'h0);
        check(q, 32'h0, "clock select reset");
        apb(1'b0, 8'h0c, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped address");
        apb(1'b1, A_CLK, 32'h10);
        foreach (rows[i]) begin
            apb(1'b1, A_SC, {27'h0, rows[i].ch});
            @(posedge pclk);
            check({27'h0, selected_analog_input}, {27'h0, rows[i].ch}, "mux");
            poll_done();
            check({31'h0, q[7]}, 32'h1, "done flag");
            apb(1'b0, A_RES, 32'h0);
            check(q, {24'h0, rows[i].res}, "result");
            repeat (40) @(posedge pclk);
            apb(1'b0, A_SC, 32'h0);
            check({31'h0, q[7]}, 32'h0, "single stops, flag cleared");
        end
        $display("test table done");
        apb(1'b1, A_RES, 32'haa);
        apb(1'b0, A_RES, 32'h0);
        check(q, 32'h0, "result read only");
        apb(1'b1, A_SC, 32'h45);
        wait_irq();
        check({31'h0, conv_irq}, 32'h1, "irq raised");
        apb(1'b0, A_SC, 32'h0);
        check({24'h0, q[7:0]}, 32'h45, "flag masked");
        apb(1'b0, A_RES, 32'h0);
        check(q, 32'h58, "irq result");
        @(posedge pclk);
        check({31'h0, conv_irq}, 32'h0, "irq dropped by read");
        $display("test irq done");
        foreach (divs[i]) begin
            nd = divs[i][2] ? 16 : (1 << divs[i]);
            apb(1'b1, A_CLK, {24'h0, divs[i], 5'h10});
            apb(1'b1, A_SC, 32'h45);
            wait_irq();
            check(32'(n >= 15 * nd + 2 && n <= 17 * nd + 6), 32'h1, "divided time");
            apb(1'b1, A_SC, 32'h1f);
            @(posedge pclk);
            check({31'h0, conv_irq}, 32'h0, "irq dropped by write");
        end
        apb(1'b1, A_CLK, 32'h00);
        apb(1'b1, A_SC, 32'h45);
        wait_irq();
        check(32'(n >= 62 && n <= 74), 32'h1, "crystal source time");
        $display("test clocking done");
        apb(1'b1, A_CLK, 32'h10);
        apb(1'b1, A_SC, 32'h23);
        poll_done();
        apb(1'b0, A_RES, 32'h0);
        check(q, 32'h36, "continuous first");
        poll_done();
        check({31'h0, q[7]}, 32'h1, "continuous again");
        apb(1'b1, A_SC, 32'h1f);
        @(posedge pclk);
        check({31'h0, conv_power_on}, 32'h0, "power off code");
        repeat (40) @(posedge pclk);
        apb(1'b0, A_SC, 32'h0);
        check(q, 32'h1f, "idle when off");
        $display("test continuous done");
        apb(1'b1, A_SC, 32'h45);
        repeat (5) @(posedge pclk);
        stop_mode <= 1'b1;
        repeat (60) @(posedge pclk);
        check({31'h0, conv_irq}, 32'h0, "stop aborts");
        stop_mode <= 1'b0;
        apb(1'b1, A_SC, 32'h65);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_SC, 32'h0);
        check(q, 32'h1f, "mid-run reset");
        $display("test stop and reset done");
        complete_run();
    end
endmodule
